// ===== verilog/ext_bus_device.sv
// Processor end of the external bus control pins.
// Assumes the bench resolves wr, sw, ack and flag wires.
// Functional notes
// - Write strobe asserted on every outgoing write not aborted
// - Outside writer drives write strobe inward
// - Sync write select precedes strobe, abortable
// - Sync write select rises with address
// - Master drives select, slave samples direction
// - Outside party holds acknowledge low to wait
// - Slave drives acknowledge low for waits
// - Master keeps last acknowledge level
// - Suspend floats bus next cycle, SDRAM driven
// - Access stalls while suspend asserted
// - Suspend used only to break deadlock
// - Interrupts asynchronous, edge or level per line
// - Twelve flags each input or output
// - Host request: release bus, then grant
// - SDRAM controls driven while host owns bus
// - Host request beats peer requests
// - Grant held while host request held
// - Host asserts chip select to address device
// - Ready low for host access wait states
// - Ready open drain until config bit set
// - Ready driven only with select and request
// - DMA request one channel 9, two channel 8
// - Outside reader drives read strobe inward
`timescale 1ns/1ps
`default_nettype none
module ext_bus_device #(
  parameter int FLAG_W = ext_bus_pkg::FLAG_W
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  ext_bus_if.dev bus,
  input wire logic acc_req,
  input wire logic acc_write,
  input wire logic acc_cond_fail,
  output logic acc_done,
  input wire logic host_wait_active_drive_bit,
  input wire logic [ext_bus_pkg::IRQ_W-1:0] irq_edge_mode,
  input wire logic [ext_bus_pkg::IRQ_W-1:0] irq_clear,
  output logic [ext_bus_pkg::IRQ_W-1:0] irq_pending,
  input wire logic [FLAG_W-1:0] flag_dir_out,
  input wire logic [FLAG_W-1:0] flag_out_val,
  output logic [FLAG_W-1:0] flag_in_val,
  output logic [ext_bus_pkg::DMA_W-1:0] dma_ch_req,
  output logic slave_access,
  output logic slave_is_write
);
  import ext_bus_pkg::*;

  typedef enum logic [1:0] {M_IDLE, M_ADDR, M_STROBE} mst_t;

  ////////////////////////////////////////////////////////////////////
  // Synchronisers
  localparam int NS = 3 + IRQ_W + DMA_W + FLAG_W;
  logic [NS-1:0] s1_ff, s2_ff;
  wire [NS-1:0] raw_in = {bus.host_bus_request_n, bus.chip_select_n,
    bus.peer_bus_request_n, bus.irq_n, bus.external_dma_request_n,
    bus.flag_i};
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_ff <= '1;
      s2_ff <= '1;
    end else if (clk_en) begin
      s1_ff <= raw_in;
      s2_ff <= s1_ff;
    end
  end
  wire hbr_s = !s2_ff[NS-1];
  wire cs_s = !s2_ff[NS-2];
  wire peer_s = !s2_ff[NS-3];
  wire [IRQ_W-1:0] irq_s = ~s2_ff[DMA_W+FLAG_W +: IRQ_W];
  wire [DMA_W-1:0] dma_s = ~s2_ff[FLAG_W +: DMA_W];
  wire [FLAG_W-1:0] flag_s = s2_ff[FLAG_W-1:0];

  ////////////////////////////////////////////////////////////////////
  // Arbitration and bus release
  logic grant_ff, owner_ff, susp_ff, ack_keep_ff;
  wire susp = !bus.bus_suspend_tristate_n;
  wire host_win = hbr_s;
  wire peer_win = peer_s && !hbr_s;
  mst_t st_ff, nxt_st;
  wire idle = (st_ff == M_IDLE);
  wire nxt_owner = !host_win && !peer_win;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      grant_ff <= 1'b0;
      owner_ff <= 1'b1;
      susp_ff <= 1'b0;
    end else if (clk_en) begin
      susp_ff <= susp;
      if (idle)
        owner_ff <= nxt_owner;
      grant_ff <= host_win && idle && !owner_ff;
    end
  end
  assign bus.bus_drive_en = owner_ff && !susp_ff;
  assign bus.sdram_drive_en = 1'b1;
  assign bus.host_bus_grant_n = !grant_ff;

  ////////////////////////////////////////////////////////////////////
  // Master access sequencer
  logic sw_ff, wr_ff, ack_s1_ff, ack_s2_ff;
  wire ack_in = bus.ack_oe ? 1'b1 : ack_keep_ff;
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      M_IDLE:
        if (acc_req && !acc_done && owner_ff && !host_win && !susp)
          nxt_st = M_ADDR; // Done cycle keeps a held request from rerunning
      M_ADDR:
        if (acc_cond_fail) nxt_st = M_IDLE;
        else if (!susp) nxt_st = M_STROBE;
      M_STROBE:
        if (ack_in && !susp) nxt_st = M_IDLE;
      default:
        nxt_st = M_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= M_IDLE;
      sw_ff <= 1'b0;
      wr_ff <= 1'b0;
      acc_done <= 1'b0;
      ack_keep_ff <= 1'b1;
    end else if (clk_en) begin
      st_ff <= nxt_st;
      sw_ff <= (nxt_st != M_IDLE) && acc_write;
      wr_ff <= (nxt_st == M_STROBE) && acc_write;
      acc_done <= (st_ff == M_STROBE) && (nxt_st == M_IDLE);
      if (!bus.ack_oe)
        ack_keep_ff <= bus.ack_i;
    end
  end
  assign bus.sw_n_o = !sw_ff;
  assign bus.sw_n_oe = bus.bus_drive_en;
  assign bus.wr_n_o = !wr_ff;
  assign bus.wr_n_oe = bus.bus_drive_en;

  ////////////////////////////////////////////////////////////////////
  // Slave access to io_processor_registers
  logic [3:0] wait_ff, hwait_ff;
  logic sl_act_ff, dir_ff, rdy_ff;
  wire strobe_in = !owner_ff && (!bus.wr_n_i || !bus.rd_n_i);
  wire ready_sel = cs_s && hbr_s;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_ff <= 4'h0;
      sl_act_ff <= 1'b0;
      dir_ff <= 1'b0;
      hwait_ff <= HOST_WAIT_CYC;
      rdy_ff <= 1'b0;
    end else if (clk_en) begin
      if (strobe_in && !sl_act_ff) begin
        sl_act_ff <= 1'b1;
        dir_ff <= !bus.sw_n_i;
        wait_ff <= SLAVE_WAIT_CYC;
      end else if (wait_ff != 4'h0) begin
        wait_ff <= wait_ff - 4'h1;
      end else if (!strobe_in) begin
        sl_act_ff <= 1'b0;
      end
      if (!ready_sel) begin
        hwait_ff <= HOST_WAIT_CYC;
        rdy_ff <= 1'b0;
      end else if (hwait_ff != 4'h0) begin
        hwait_ff <= hwait_ff - 4'h1;
        rdy_ff <= (hwait_ff == 4'h1);
      end
    end
  end
  assign bus.ack_o = (wait_ff == 4'h0);
  assign bus.ack_oe = sl_act_ff;
  assign slave_access = sl_act_ff;
  assign slave_is_write = dir_ff;
  // Open drain drives only the low level
  assign bus.host_wait_ready_o = rdy_ff;
  assign bus.host_wait_ready_oe = ready_sel &&
    ((host_wait_active_drive_bit == READY_AD) || !rdy_ff);

  ////////////////////////////////////////////////////////////////////
  // Interrupts, flags, DMA requests
  logic [IRQ_W-1:0] irq_prev_ff;
  logic [FLAG_W-1:0] flag_out_ff, flag_oe_ff;
  wire [IRQ_W-1:0] irq_hit = irq_edge_mode & irq_s & ~irq_prev_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_prev_ff <= '0;
      irq_pending <= '0;
      flag_out_ff <= '0;
      flag_oe_ff <= '0;
      flag_in_val <= '0;
      dma_ch_req <= '0;
    end else if (clk_en) begin
      irq_prev_ff <= irq_s;
      // Set beats clear on edge lines
      irq_pending <= (irq_edge_mode & ((irq_pending & ~irq_clear) |
        irq_hit)) | (~irq_edge_mode & irq_s);
      flag_oe_ff <= flag_dir_out;
      flag_out_ff <= flag_out_val;
      flag_in_val <= flag_s;
      dma_ch_req[DMA_IDX_REQ1] <= dma_s[DMA_IDX_REQ1];
      dma_ch_req[DMA_IDX_REQ2] <= dma_s[DMA_IDX_REQ2];
    end
  end
  assign bus.flag_o = flag_out_ff;
  assign bus.flag_oe = flag_oe_ff;
endmodule
`default_nettype wire

// ===== verilog/ext_bus_pkg.sv
// Shared constants for the external parallel bus control ends.
// Assumes one 25 MHz clock shared by both ends of the bench.
package ext_bus_pkg;
  localparam int FLAG_W = 12;
  localparam int IRQ_W = 3;
  localparam int DMA_W = 2;
  localparam int SYNC_STAGES = 2;
  localparam logic [3:0] SLAVE_WAIT_CYC = 4'h2;
  localparam logic [3:0] HOST_WAIT_CYC = 4'h3;
  localparam int DMA_CH_REQ1 = 9;
  localparam int DMA_CH_REQ2 = 8;
  localparam int DMA_IDX_REQ1 = 0;
  localparam int DMA_IDX_REQ2 = 1;
  localparam logic READY_OD = 1'b0;
  localparam logic READY_AD = 1'b1;
  typedef enum logic [1:0] {
    XA_READ,
    XA_WRITE
  } xfer_kind_t;
endpackage

// ===== verilog/ext_bus_if.sv
// Interface joining the processor end and the outside party end.
// Assumes the bench resolves shared wires from the enables.
`timescale 1ns/1ps
`default_nettype none
interface ext_bus_if;
  logic wr_n_o, wr_n_oe, wr_n_i;
  logic rd_n_i;
  logic sw_n_o, sw_n_oe, sw_n_i;
  logic ack_o, ack_oe, ack_i;
  logic bus_suspend_tristate_n;
  logic host_bus_request_n;
  logic host_bus_grant_n;
  logic chip_select_n;
  logic host_wait_ready_o, host_wait_ready_oe;
  logic bus_drive_en;
  logic sdram_drive_en;
  logic [2:0] irq_n;
  logic [11:0] flag_o, flag_oe, flag_i;
  logic [1:0] external_dma_request_n;
  logic peer_bus_request_n;
  logic far_wr_n_o, far_wr_n_oe, far_rd_n_o;
  logic far_sw_n_o, far_sw_n_oe, far_ack_o, far_ack_oe;
  modport dev(
    output wr_n_o, wr_n_oe, sw_n_o, sw_n_oe, ack_o, ack_oe,
    output host_bus_grant_n, host_wait_ready_o, host_wait_ready_oe,
    output bus_drive_en, sdram_drive_en, flag_o, flag_oe,
    input wr_n_i, rd_n_i, sw_n_i, ack_i, bus_suspend_tristate_n,
    input host_bus_request_n, chip_select_n, irq_n, flag_i,
    input external_dma_request_n, peer_bus_request_n
  );
  modport far(
    output far_wr_n_o, far_wr_n_oe, far_rd_n_o,
    output far_sw_n_o, far_sw_n_oe, far_ack_o, far_ack_oe,
    output bus_suspend_tristate_n, host_bus_request_n, chip_select_n,
    output irq_n, external_dma_request_n, peer_bus_request_n,
    input wr_n_i, sw_n_i, ack_i, host_bus_grant_n,
    input host_wait_ready_o, host_wait_ready_oe, bus_drive_en
  );
endinterface
`default_nettype wire

// ===== verilog/ext_bus_far.sv
// Outside party end: host, memory and peer master in one.
// Assumes the bench joins it to the processor end by the interface.
`timescale 1ns/1ps
`default_nettype none
module ext_bus_far (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  ext_bus_if.far bus,
  input wire logic host_req,
  input wire logic host_cs,
  input wire logic deadlock_break,
  input wire logic peer_write,
  input wire logic peer_read,
  input wire logic mem_wait,
  input wire logic [ext_bus_pkg::IRQ_W-1:0] irq_req,
  input wire logic [ext_bus_pkg::DMA_W-1:0] dma_req,
  input wire logic peer_req,
  output logic host_granted,
  output logic host_ready
);
  import ext_bus_pkg::*;

  logic g1_ff, g2_ff, r1_ff, r2_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      g1_ff <= 1'b0;
      g2_ff <= 1'b0;
      r1_ff <= 1'b1;
      r2_ff <= 1'b1;
      host_granted <= 1'b0;
      host_ready <= 1'b1;
    end else if (clk_en) begin
      g1_ff <= !bus.host_bus_grant_n;
      g2_ff <= g1_ff;
      r1_ff <= bus.host_wait_ready_oe ? bus.host_wait_ready_o : 1'b1;
      r2_ff <= r1_ff;
      host_granted <= g2_ff && host_req;
      host_ready <= r2_ff;
    end
  end
  wire own = host_granted || (peer_req && !bus.bus_drive_en);
  assign bus.host_bus_request_n = !host_req;
  assign bus.chip_select_n = !(host_cs && host_req);
  assign bus.bus_suspend_tristate_n = !deadlock_break;
  assign bus.far_wr_n_o = !(peer_write && own);
  assign bus.far_wr_n_oe = own;
  assign bus.far_rd_n_o = !(peer_read && own);
  assign bus.far_sw_n_o = !(peer_write && own);
  assign bus.far_sw_n_oe = own;
  assign bus.far_ack_o = !mem_wait;
  assign bus.far_ack_oe = !own && mem_wait;
  assign bus.irq_n = ~irq_req;
  assign bus.external_dma_request_n = ~dma_req;
  assign bus.peer_bus_request_n = !peer_req;
endmodule
`default_nettype wire

// ===== tb/ext_bus_checker.sv
// Concurrent checks on the shared bus control wires.
// Assumes one clock and the bench placing it beside the interface.
`timescale 1ns/1ps
`default_nettype none
module ext_bus_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wr_n_o,
  input wire logic wr_n_oe,
  input wire logic sw_n_o,
  input wire logic ack_o,
  input wire logic ack_oe,
  input wire logic bus_suspend_tristate_n,
  input wire logic host_bus_request_n,
  input wire logic host_bus_grant_n,
  input wire logic chip_select_n,
  input wire logic host_wait_ready_o,
  input wire logic host_wait_ready_oe,
  input wire logic bus_drive_en,
  input wire logic sdram_drive_en
);
  logic [3:0] sel_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Select history covers the synchroniser lag after release
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) sel_ff <= 4'h0;
    else sel_ff <= {sel_ff[2:0], !chip_select_n && !host_bus_request_n};
  end
  ////////////////////////////////////////////////////////////////////////
  property p_release_then_grant;
    $fell(host_bus_grant_n) |-> !bus_drive_en && $past(!bus_drive_en);
  endproperty
  a_release_then_grant: assert property (p_release_then_grant)
    else $error("grant before bus release");
  property p_grant_held;
    !host_bus_grant_n && !host_bus_request_n |=> !host_bus_grant_n;
  endproperty
  a_grant_held: assert property (p_grant_held)
    else $error("grant dropped under request");
  property p_sdram_driven;
    sdram_drive_en;
  endproperty
  a_sdram_driven: assert property (p_sdram_driven)
    else $error("sdram controls floated");
  property p_ready_only_selected;
    host_wait_ready_oe |->
      (|sel_ff) || (!chip_select_n && !host_bus_request_n);
  endproperty
  a_ready_only_selected: assert property (p_ready_only_selected)
    else $error("ready driven without select");
  property p_sw_before_wr;
    $fell(wr_n_o) && wr_n_oe |-> !sw_n_o && $past(!sw_n_o);
  endproperty
  a_sw_before_wr: assert property (p_sw_before_wr)
    else $error("write strobe without early select");
  property p_suspend_float;
    !bus_suspend_tristate_n |=> !bus_drive_en;
  endproperty
  a_suspend_float: assert property (p_suspend_float)
    else $error("bus driven under suspend");
  property p_slave_ack_wait;
    $rose(ack_oe) |-> !ack_o [*2] ##1 ack_o;
  endproperty
  a_slave_ack_wait: assert property (p_slave_ack_wait)
    else $error("slave ack wait length wrong");
  property p_ready_wait;
    $rose(host_wait_ready_oe) |->
      !host_wait_ready_o [*3] ##1 (host_wait_ready_o || !host_wait_ready_oe);
  endproperty
  a_ready_wait: assert property (p_ready_wait)
    else $error("host wait length wrong");
endmodule
`default_nettype wire

// ===== tb/external_bus_host_control_test.sv
// Bench joining both bus control ends across the interface.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module external_bus_host_control_test;
  import ext_bus_pkg::*;
  logic clk = 0, reset_n = 0, acc_req = 0, acc_write = 0, acc_cond_fail = 0;
  logic host_wait_active_drive_bit = 0, host_req = 0, host_cs = 0;
  logic deadlock_break = 0, peer_write = 0, peer_read = 0, mem_wait = 0;
  logic peer_req = 0, acc_done, slave_access, slave_is_write;
  logic host_granted, host_ready;
  logic [2:0] irq_edge_mode = 0, irq_clear = 0, irq_req = 0, irq_pending;
  logic [2:0] pend = 0, prev = 0;
  logic [11:0] flag_dir_out = 0, flag_out_val = 0, ext_flag = 0;
  logic [11:0] flag_in_val, exp_f;
  logic [1:0] dma_req = 0, dma_ch_req;
  int n_errors = 0, num_checks = 0, cyc, wr_cnt = 0, od_bad = 0, lo_cnt;
  int n, exp_q[$];
  ext_bus_if bus_if();
  always #20 clk = ~clk;
  // Shared wires resolved from the drivers' enables; read strobe taken straight from the far end
  assign bus_if.wr_n_i = bus_if.wr_n_oe ? bus_if.wr_n_o :
    bus_if.far_wr_n_oe ? bus_if.far_wr_n_o : 1'b1;
  assign bus_if.sw_n_i = bus_if.sw_n_oe ? bus_if.sw_n_o :
    bus_if.far_sw_n_oe ? bus_if.far_sw_n_o : 1'b1;
  assign bus_if.ack_i = bus_if.ack_oe ? bus_if.ack_o :
    bus_if.far_ack_oe ? bus_if.far_ack_o : 1'b1;
  assign bus_if.rd_n_i = bus_if.far_rd_n_o;
  assign bus_if.flag_i = (bus_if.flag_oe & bus_if.flag_o) |
    (~bus_if.flag_oe & ext_flag);
  ext_bus_device ext_bus_device_i (.clk(clk), .reset_n(reset_n),
    .clk_en(1'b1), .bus(bus_if), .acc_req(acc_req), .acc_write(acc_write),
    .acc_cond_fail(acc_cond_fail), .acc_done(acc_done),
    .host_wait_active_drive_bit(host_wait_active_drive_bit),
    .irq_edge_mode(irq_edge_mode), .irq_clear(irq_clear),
    .irq_pending(irq_pending), .flag_dir_out(flag_dir_out),
    .flag_out_val(flag_out_val), .flag_in_val(flag_in_val),
    .dma_ch_req(dma_ch_req), .slave_access(slave_access),
    .slave_is_write(slave_is_write));
  ext_bus_far ext_bus_far_i (.clk(clk), .reset_n(reset_n), .clk_en(1'b1),
    .bus(bus_if), .host_req(host_req), .host_cs(host_cs),
    .deadlock_break(deadlock_break), .peer_write(peer_write),
    .peer_read(peer_read), .mem_wait(mem_wait), .irq_req(irq_req),
    .dma_req(dma_req), .peer_req(peer_req), .host_granted(host_granted),
    .host_ready(host_ready));
  ext_bus_checker ext_bus_checker_i (.clk(clk), .reset_n(reset_n),
    .wr_n_o(bus_if.wr_n_o), .wr_n_oe(bus_if.wr_n_oe),
    .sw_n_o(bus_if.sw_n_o), .ack_o(bus_if.ack_o), .ack_oe(bus_if.ack_oe),
    .bus_suspend_tristate_n(bus_if.bus_suspend_tristate_n),
    .host_bus_request_n(bus_if.host_bus_request_n),
    .host_bus_grant_n(bus_if.host_bus_grant_n),
    .chip_select_n(bus_if.chip_select_n),
    .host_wait_ready_o(bus_if.host_wait_ready_o),
    .host_wait_ready_oe(bus_if.host_wait_ready_oe),
    .bus_drive_en(bus_if.bus_drive_en),
    .sdram_drive_en(bus_if.sdram_drive_en));
  ////////////////////////////////////////////////////////////////////////
  always @(negedge bus_if.wr_n_o) if (bus_if.wr_n_oe === 1'b1) wr_cnt++;
  always @(posedge clk) begin
    if (bus_if.host_wait_ready_oe === 1'b1 &&
        bus_if.host_wait_ready_o === 1'b0)
      lo_cnt++;
    if (!host_wait_active_drive_bit && bus_if.host_wait_ready_oe === 1'b1 &&
        bus_if.host_wait_ready_o !== 1'b0) od_bad++;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task final_report;
    if (n_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  // Abort never completes, so the bounded wait also ends it
  task access(input logic w, input logic ab, input logic mw);
    @(posedge clk);
    acc_req <= 1'b1;
    acc_write <= w;
    acc_cond_fail <= ab;
    mem_wait <= mw;
    cyc = 0;
    do begin
      @(posedge clk);
      cyc++;
      if (cyc == 6) mem_wait <= 1'b0;
    end while (acc_done !== 1'b1 && cyc < 60);
    acc_req <= 1'b0;
    acc_cond_fail <= 1'b0;
  endtask
  initial begin
    #400000;
    n_errors++;
    final_report;
  end
  initial begin
    void'($urandom(32'hdc71ae83));
    tick(16);
    reset_n <= 1'b1;
    tick(2);
    for (int i = 0; i < 6; i++) begin
      n = wr_cnt;
      access(i[0] || i == 4, i == 4, i == 2 || i == 3);
      exp_q.push_back((i[0] && i != 4) ? 1 : 0);
      chk(wr_cnt - n, exp_q.pop_front());
      if (i != 4) chk(cyc > ((i == 2 || i == 3) ? 6 : 2) && cyc < 60, 1);
    end
    deadlock_break <= 1'b1;
    tick(4);
    chk(bus_if.bus_drive_en, 0);
    fork
      access(1'b1, 1'b0, 1'b0);
      begin tick(15); deadlock_break <= 1'b0; end
    join
    chk(cyc > 14 && cyc < 60, 1);
    host_req <= 1'b1;
    peer_req <= 1'b1;
    for (cyc = 0; cyc < 40 && host_granted !== 1'b1; cyc++) tick(1);
    chk(bus_if.bus_drive_en, 0);
    chk(bus_if.host_bus_grant_n, 0);
    for (int m = 0; m < 2; m++) begin
      host_wait_active_drive_bit <= m[0];
      host_cs <= 1'b1;
      lo_cnt = 0;
      tick(20);
      chk(lo_cnt, HOST_WAIT_CYC);
      chk(host_ready, 1);
      host_cs <= 1'b0;
      tick(8);
    end
    chk(od_bad, 0);
    chk(bus_if.host_bus_grant_n, 0);
    host_req <= 1'b0;
    tick(10);
    chk(bus_if.host_bus_grant_n, 1);
    for (int m = 0; m < 2; m++) begin
      peer_write <= !m[0];
      peer_read <= m[0];
      tick(6);
      chk(slave_access, 1);
      chk(slave_is_write, !m[0]);
      peer_write <= 1'b0;
      peer_read <= 1'b0;
      tick(6);
    end
    peer_req <= 1'b0;
    irq_edge_mode <= 3'($urandom);
    for (int i = 0; i < 8; i++) begin
      irq_req <= 3'($urandom);
      dma_req <= 2'($urandom);
      flag_dir_out <= 12'($urandom);
      flag_out_val <= 12'($urandom);
      ext_flag <= 12'($urandom);
      tick(8);
      pend = (irq_edge_mode & (pend | (irq_req & ~prev))) |
        (~irq_edge_mode & irq_req);
      exp_f = (flag_dir_out & flag_out_val) | (~flag_dir_out & ext_flag);
      chk(irq_pending, pend);
      chk(flag_in_val, exp_f);
      chk(bus_if.flag_oe, flag_dir_out);
      chk(dma_ch_req[DMA_IDX_REQ1], dma_req[0]);
      chk(dma_ch_req[DMA_IDX_REQ2], dma_req[1]);
      irq_clear <= irq_edge_mode;
      tick(1);
      irq_clear <= 3'h0;
      tick(4);
      pend = pend & ~irq_edge_mode;
      prev = irq_req;
    end
    final_report;
  end
endmodule
`default_nettype wire
